// file: src/edc_map.svh
// timing figures and counts for the edo memory controller
`ifndef EDC_MAP_SVH
`define EDC_MAP_SVH
`define EDC_CLK_PS        8000
`define EDC_T_RC_PS       110000
`define EDC_T_RAS_PS      60000
`define EDC_T_RP_PS       40000
`define EDC_T_RCD_PS      20000
`define EDC_T_CAS_PS      15000
`define EDC_T_CP_PS       10000
`define EDC_T_PC_PS       40000
`define EDC_T_CSR_PS      5000
`define EDC_T_CHR_PS      10000
`define EDC_T_CRP_PS      5000
`define EDC_T_OEHC_PS     15000
`define EDC_T_RWL_PS      15000
`define EDC_T_CWD_PS      40000
`define EDC_T_RWD_PS      85000
`define EDC_T_RASMAX_NS   10000
`define EDC_T_RASPMAX_NS  100000
`define EDC_MIN_CYC(ps)   (((ps) + `EDC_CLK_PS - 1) / `EDC_CLK_PS)
`define EDC_C_RC          `EDC_MIN_CYC(`EDC_T_RC_PS)
`define EDC_C_RAS         `EDC_MIN_CYC(`EDC_T_RAS_PS)
`define EDC_C_RP          `EDC_MIN_CYC(`EDC_T_RP_PS)
`define EDC_C_RCD         `EDC_MIN_CYC(`EDC_T_RCD_PS)
`define EDC_C_CAS         `EDC_MIN_CYC(`EDC_T_CAS_PS)
`define EDC_C_CP          `EDC_MIN_CYC(`EDC_T_CP_PS)
`define EDC_C_PC          `EDC_MIN_CYC(`EDC_T_PC_PS)
`define EDC_C_CSR         `EDC_MIN_CYC(`EDC_T_CSR_PS)
`define EDC_C_CHR         `EDC_MIN_CYC(`EDC_T_CHR_PS)
`define EDC_C_CRP         `EDC_MIN_CYC(`EDC_T_CRP_PS)
`define EDC_C_OEHC        `EDC_MIN_CYC(`EDC_T_OEHC_PS)
`define EDC_C_RWL         `EDC_MIN_CYC(`EDC_T_RWL_PS)
`define EDC_C_RASMAX      ((`EDC_T_RASMAX_NS * 1000) / `EDC_CLK_PS)
`define EDC_C_RASPMAX     ((`EDC_T_RASPMAX_NS * 1000) / `EDC_CLK_PS)
`define EDC_T_PWRUP_US    200
`define EDC_C_PWRUP       ((`EDC_T_PWRUP_US * 1000000) / `EDC_CLK_PS)
`define EDC_T_REF_MS      16
`define EDC_REF_ROWS      1024
`define EDC_C_REFINT      ((((`EDC_T_REF_MS * 1000000) / `EDC_REF_ROWS) * 1000) / `EDC_CLK_PS)
`define EDC_WAKE_CYCLES   8
`define EDC_ROW_W         10
`define EDC_DQ_W          16
`define EDC_CNT_W         16
`endif

// file: src/edc_pkg.sv
// types for the edo memory controller
package edc_pkg;
  typedef struct packed {
    logic        wr;
    logic [1:0]  be;
    logic [19:0] addr;
    logic [15:0] wdata;
  } edc_req_t;

  typedef struct packed {
    logic        ras_n;
    logic        low_byte_column_strobe_n;
    logic        high_byte_column_strobe_n;
    logic        we_n;
    logic        oe_n;
    logic [9:0]  addr;
    logic [15:0] dq_o;
    logic        dq_oe;
  } edc_pins_t;

  typedef enum logic [3:0] {
    ST_PWRUP, ST_WAKE, ST_IDLE, ST_RCD, ST_CAS, ST_CP, ST_CLOSE, ST_PRE,
    ST_CBR_CSR, ST_CBR_RAS, ST_CBR_END
  } edc_state_t;

  typedef struct packed {
    edc_state_t  st;
    logic [23:0] cnt;
    logic [15:0] ras_cnt;
    logic [15:0] ref_cnt;
    logic [11:0] ref_owe;
    logic [3:0]  wake;
    edc_req_t    req;
    logic        rvalid;
    logic        busy;
    logic        ready;
    logic [15:0] rdata;
    edc_pins_t   pins;
  } edc_state_all_t;
endpackage

// file: src/edc_ctrl.sv
// edo page-mode memory controller driving the strobes and multiplexed address
// Notes on behaviour
// - random cycles last at least the full row cycle time
// - column strobe falls at least 20 ns after row strobe falls
// - column strobes stay high at least the column precharge time
// - column address held until lead time before row strobe rises
// - wait 5 ns after column strobe rises before next row fall
// - page-mode column cycles last at least the page cycle time
// - page-mode row strobe low at most 100K ns, at least minimum; code clips the limit to 65535 cycles (about 524 us)
// - page read-write cycles last at least 56 ns
// - read-modify-write: write strobe late enough after row fall
// - read-write: write strobe late enough after column fall
// - write strobe falls at least lead time before row rises
// - 1,024 refreshes spread across every 16 ms
// - column strobe low 5 ns before row falls for refresh
// - column strobe held low after row fall during refresh
// - write-strobe output disable pulse at least 10 ns
// - last column fall to first column rise at least 10 ns
// - output enable high 15 ns after column strobe rises
// - 200 us pause then eight refreshes; repeat after overdue refresh
`timescale 1ns/1ps
`include "edc_map.svh"
module edc_ctrl #(
  parameter int unsigned PWRUP_CYC  = `EDC_C_PWRUP,
  parameter int unsigned REFINT_CYC = `EDC_C_REFINT,
  parameter int unsigned RASP_CYC   = `EDC_C_RASPMAX
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic              i_req_valid,
  input  wire edc_pkg::edc_req_t i_req,
  output logic                   o_req_ready,
  output logic                   o_rvalid,
  output logic [15:0]            o_rdata,
  output logic                   o_busy,
  output edc_pkg::edc_pins_t     o_pins,
  input  wire logic [15:0]       i_dq
);
  import edc_pkg::*;

  localparam logic [23:0] C_RP     = 24'(`EDC_C_RP);
  localparam logic [23:0] C_RCD    = 24'(`EDC_C_RCD);
  localparam logic [23:0] C_CAS    = 24'(`EDC_C_CAS);
  localparam logic [23:0] C_CP     = 24'(`EDC_C_CP);
  localparam logic [23:0] C_CSR    = 24'(`EDC_C_CSR);
  localparam logic [23:0] C_CHR    = 24'(`EDC_C_CHR);
  localparam logic [23:0] C_OEHC   = 24'(`EDC_C_OEHC);
  localparam logic [23:0] C_PWRUP  = 24'(PWRUP_CYC);
  localparam logic [15:0] C_RASMIN = 16'(`EDC_C_RAS);
  localparam logic [15:0] C_RASMAX = 16'(`EDC_C_RASMAX);
  localparam logic [15:0] C_RASPMX = 16'((RASP_CYC > 65535) ? 65535 : RASP_CYC);
  localparam logic [15:0] C_REFINT = 16'(REFINT_CYC);
  localparam logic [15:0] C_PCMIN  = 16'(`EDC_C_PC);
  localparam logic [3:0]  C_WAKE   = 4'(`EDC_WAKE_CYCLES);

  edc_state_all_t s_ff;
  edc_state_all_t nxt_s;

  function automatic edc_pins_t pins_idle();
    edc_pins_t p;
    p        = '0;
    p.ras_n  = 1'b1;
    p.low_byte_column_strobe_n = 1'b1;
    p.high_byte_column_strobe_n = 1'b1;
    p.we_n   = 1'b1;
    p.oe_n   = 1'b1;
    return p;
  endfunction

  logic ref_due;
  logic ras_limit;
  logic same_row;

  always_comb begin
    ref_due   = (s_ff.ref_owe != 12'h000);
    ras_limit = (s_ff.ras_cnt >= C_RASPMX - 16'(`EDC_C_RWL) - 16'h0010);
    same_row  = (i_req.addr[19:10] == s_ff.req.addr[19:10]);
  end

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.rvalid = 1'b0;
    nxt_s.ready  = 1'b0;
    if (s_ff.cnt != 24'h000000) begin
      nxt_s.cnt = s_ff.cnt - 24'h000001;
    end
    if (!s_ff.pins.ras_n && s_ff.ras_cnt != 16'hFFFF) begin
      nxt_s.ras_cnt = s_ff.ras_cnt + 16'h0001;
    end
    // refresh pacing: one row owed per interval, overdue triggers wake cycles
    if (s_ff.ref_cnt >= C_REFINT - 16'h0001) begin
      nxt_s.ref_cnt = 16'h0000;
      if (s_ff.ref_owe == 12'(`EDC_REF_ROWS)) begin
        nxt_s.wake = C_WAKE;
      end else begin
        nxt_s.ref_owe = s_ff.ref_owe + 12'h001;
      end
    end else if (s_ff.st != ST_PWRUP) begin
      nxt_s.ref_cnt = s_ff.ref_cnt + 16'h0001;
    end
    case (s_ff.st)
      ST_PWRUP: begin
        nxt_s.busy = 1'b1;
        if (s_ff.cnt == 24'h000000) begin
          nxt_s.wake = C_WAKE;
          nxt_s.st   = ST_IDLE;
        end
      end
      ST_IDLE: begin
        nxt_s.pins = pins_idle();
        nxt_s.busy = (s_ff.wake != 4'h0);
        if (s_ff.cnt == 24'h000000) begin
          if (s_ff.wake != 4'h0 || ref_due) begin
            nxt_s.pins.low_byte_column_strobe_n = 1'b0;
            nxt_s.pins.high_byte_column_strobe_n = 1'b0;
            nxt_s.cnt         = C_CSR;
            nxt_s.st          = ST_CBR_CSR;
            nxt_s.busy        = 1'b1;
          end else if (i_req_valid) begin
            nxt_s.req        = i_req;
            nxt_s.ready      = 1'b1;
            nxt_s.busy       = 1'b1;
            nxt_s.pins.addr  = i_req.addr[19:10];
            nxt_s.pins.ras_n = 1'b0;
            nxt_s.ras_cnt    = 16'h0000;
            nxt_s.cnt        = C_RCD;
            nxt_s.st         = ST_RCD;
          end
        end
      end
      ST_RCD, ST_CP: begin
        if (s_ff.cnt == 24'h000000) begin
          nxt_s.pins.addr   = s_ff.req.addr[9:0];
          nxt_s.pins.low_byte_column_strobe_n = ~s_ff.req.be[0];
          nxt_s.pins.high_byte_column_strobe_n = ~s_ff.req.be[1];
          nxt_s.pins.we_n   = ~s_ff.req.wr;
          nxt_s.pins.oe_n   = s_ff.req.wr;
          nxt_s.pins.dq_o   = s_ff.req.wdata;
          nxt_s.pins.dq_oe  = s_ff.req.wr;
          nxt_s.cnt         = (C_CAS > C_PCMIN - C_CP) ? C_CAS : 24'(C_PCMIN) - C_CP;
          nxt_s.st          = ST_CAS;
        end
      end
      ST_CAS: begin
        if (s_ff.cnt == 24'h000000) begin
          if (!s_ff.req.wr) begin
            nxt_s.rdata  = i_dq;
            nxt_s.rvalid = 1'b1;
          end
          nxt_s.pins.low_byte_column_strobe_n = 1'b1;
          nxt_s.pins.high_byte_column_strobe_n = 1'b1;
          nxt_s.pins.we_n   = 1'b1;
          nxt_s.pins.dq_oe  = 1'b0;
          nxt_s.cnt         = C_CP;
          if (i_req_valid && same_row && !ref_due && s_ff.wake == 4'h0 && !ras_limit) begin
            nxt_s.req   = i_req;
            nxt_s.ready = 1'b1;
            nxt_s.st    = ST_CP;
          end else begin
            nxt_s.st = ST_CLOSE;
          end
        end
      end
      ST_CLOSE: begin
        // hold row for minimum width and column precharge time after column rise
        if (s_ff.cnt == 24'h000000 && s_ff.ras_cnt >= C_RASMIN) begin
          nxt_s.pins.ras_n = 1'b1;
          nxt_s.cnt        = (C_RP > C_OEHC) ? C_RP : C_OEHC;
          nxt_s.st         = ST_PRE;
        end
      end
      ST_PRE: begin
        nxt_s.pins.oe_n = 1'b1;
        if (s_ff.cnt == 24'h000000) begin
          nxt_s.pins = pins_idle();
          nxt_s.st   = ST_IDLE;
        end
      end
      ST_CBR_CSR: begin
        if (s_ff.cnt == 24'h000000) begin
          nxt_s.pins.ras_n = 1'b0;
          nxt_s.ras_cnt    = 16'h0000;
          nxt_s.cnt        = C_CHR;
          nxt_s.st         = ST_CBR_RAS;
        end
      end
      ST_CBR_RAS: begin
        if (s_ff.cnt == 24'h000000) begin
          nxt_s.pins.low_byte_column_strobe_n = 1'b1;
          nxt_s.pins.high_byte_column_strobe_n = 1'b1;
          nxt_s.st          = ST_CBR_END;
        end
      end
      ST_CBR_END: begin
        if (s_ff.ras_cnt >= C_RASMIN) begin
          nxt_s.pins.ras_n = 1'b1;
          nxt_s.cnt        = C_RP;
          nxt_s.st         = ST_PRE;
          if (s_ff.wake != 4'h0) begin
            nxt_s.wake = s_ff.wake - 4'h1;
          end else if (s_ff.ref_owe != 12'h000) begin
            nxt_s.ref_owe = nxt_s.ref_owe - 12'h001;
          end
        end
      end
      default: begin
        nxt_s.st   = ST_IDLE;
        nxt_s.pins = pins_idle();
      end
    endcase
    if (s_ff.ras_cnt >= C_RASMAX && s_ff.st == ST_CLOSE) begin
      nxt_s.pins.ras_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_ff         <= '0;
      s_ff.st      <= ST_PWRUP;
      s_ff.cnt     <= C_PWRUP;
      s_ff.busy    <= 1'b1;
      s_ff.pins    <= pins_idle();
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_req_ready = s_ff.ready;
  assign o_rvalid    = s_ff.rvalid;
  assign o_rdata     = s_ff.rdata;
  assign o_busy      = s_ff.busy;
  assign o_pins      = s_ff.pins;
endmodule

// file: testbench/edc_ctrl_checker.sv
// pin timing checks for the edo memory controller
`timescale 1ns/1ps
module edc_ctrl_checker (
  input wire logic               i_clk_sys,
  input wire logic               i_sys_rst,
  input wire edc_pkg::edc_pins_t o_pins
);
  import edc_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire ras_n  = o_pins.ras_n;
  wire low_byte_column_strobe_n = o_pins.low_byte_column_strobe_n;
  wire high_byte_column_strobe_n = o_pins.high_byte_column_strobe_n;
  wire we_n   = o_pins.we_n;
  ras_pre_a: assert property ($rose(ras_n) |-> ras_n [*5])
    else $error("row strobe precharge too short");
  ras_width_a: assert property ($fell(ras_n) |-> !ras_n [*8])
    else $error("row strobe pulse too short");
  row_cycle_a: assert property ($fell(ras_n) |=> !$fell(ras_n) [*8] ##1 !$fell(ras_n) [*5])
    else $error("row cycle too short");
  ras_cas_delay_a: assert property ($fell(ras_n) && low_byte_column_strobe_n && high_byte_column_strobe_n |-> (low_byte_column_strobe_n && high_byte_column_strobe_n) [*3])
    else $error("column strobe too soon after row strobe");
  cas_pre_a: assert property ($rose(low_byte_column_strobe_n) |-> low_byte_column_strobe_n [*2])
    else $error("column strobe precharge too short");
  cas_setup_a: assert property ($fell(ras_n) && !low_byte_column_strobe_n |-> $past(low_byte_column_strobe_n) == 1'b0)
    else $error("refresh column strobe set up late");
  cas_hold_a: assert property ($fell(ras_n) && !low_byte_column_strobe_n |-> !low_byte_column_strobe_n [*2])
    else $error("refresh column strobe released early");
  cas_ras_pre_a: assert property ($fell(ras_n) && low_byte_column_strobe_n |-> $past(low_byte_column_strobe_n) && $past(high_byte_column_strobe_n))
    else $error("row strobe fell too soon after column strobe");
  write_lead_a: assert property ($fell(we_n) |-> !ras_n [*3])
    else $error("write strobe too close to row strobe rise");
endmodule
bind edc_ctrl edc_ctrl_checker u_edc_ctrl_checker (
  .i_clk_sys (i_clk_sys),
  .i_sys_rst (i_sys_rst),
  .o_pins    (o_pins)
);

// file: testbench/edc_mem_model.sv
// behavioural edo memory answering the controller pins
`timescale 1ns/1ps
module edc_mem_model (
  input  wire edc_pkg::edc_pins_t i_pins,
  output logic [15:0]             o_dq,
  output int                      o_ref_cnt
);
  import edc_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] dval = 16'h0000;
  logic [15:0] w;
  logic [9:0]  row  = 10'h000;
  logic [9:0]  rcnt = 10'h000;
  logic        dv   = 1'b0;
  int          k;
  wire         ras_n = i_pins.ras_n;
  wire         cas_n = i_pins.low_byte_column_strobe_n & i_pins.high_byte_column_strobe_n;
  initial o_ref_cnt = 0;
  always @(negedge ras_n) begin
    if (!cas_n) begin
      rcnt++;
      o_ref_cnt++;
    end else row = i_pins.addr;
  end
  always @(negedge cas_n) begin
    k = {row, i_pins.addr};
    w = mem.exists(k) ? mem[k] : (k[15:0] ^ 16'hA5A5);
    if (!ras_n && !i_pins.we_n) begin
      if (!i_pins.low_byte_column_strobe_n) w[7:0] = i_pins.dq_o[7:0];
      if (!i_pins.high_byte_column_strobe_n) w[15:8] = i_pins.dq_o[15:8];
      mem[k] = w;
      dv = 1'b0;
    end else if (!ras_n) begin
      dval = w;
      dv = 1'b1;
    end
  end
  always @(posedge ras_n) dv = 1'b0;
  // released bus shows the inverse of the last word read
  assign o_dq = (dv && !i_pins.oe_n && i_pins.we_n) ? dval : ~dval;
endmodule

// file: testbench/edc_ctrl_tb_top.sv
// self-checking bench for the edo memory controller
`timescale 1ns/1ps
module edc_ctrl_tb_top;
  import edc_pkg::*;
  typedef struct packed {
    logic wr; logic [1:0] be; logic [19:0] a; logic [15:0] d; logic [15:0] x;
  } edc_row_t;
  logic        i_clk_sys   = 1'b0;
  logic        i_sys_rst   = 1'b1;
  logic        i_req_valid = 1'b0;
  edc_req_t    i_req       = '0;
  logic        o_req_ready, o_rvalid, o_busy;
  logic [15:0] o_rdata, i_dq;
  edc_pins_t   o_pins;
  int          err_count = 0, cmp_count = 0, refs, r0, n;
  edc_row_t    rows [11] = '{
    '{1'h1, 2'h3, 20'h00010, 16'h1234, 16'h0000}, '{1'h1, 2'h3, 20'h00011, 16'hABCD, 16'h0000},
    '{1'h0, 2'h3, 20'h00010, 16'h0000, 16'h1234}, '{1'h0, 2'h3, 20'h00011, 16'h0000, 16'hABCD},
    '{1'h1, 2'h1, 20'h00010, 16'hFF00, 16'h0000}, '{1'h1, 2'h2, 20'h00011, 16'h5577, 16'h0000},
    '{1'h0, 2'h3, 20'h00010, 16'h0000, 16'h1200}, '{1'h0, 2'h3, 20'h00011, 16'h0000, 16'h55CD},
    '{1'h0, 2'h3, 20'hFFC00, 16'h0000, 16'h59A5}, '{1'h1, 2'h3, 20'hFFC00, 16'h0F0F, 16'h0000},
    '{1'h0, 2'h3, 20'hFFC00, 16'h0000, 16'h0F0F}};
  edc_ctrl #(.PWRUP_CYC(20), .REFINT_CYC(200), .RASP_CYC(100)) u_edc_ctrl (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_busy(o_busy),
    .o_pins(o_pins), .i_dq(i_dq));
  edc_mem_model u_edc_mem_model (.i_pins(o_pins), .o_dq(i_dq), .o_ref_cnt(refs));
  always #4 i_clk_sys = ~i_clk_sys;
  task automatic chk_d(string s, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_n(string s, int e, int g);
    cmp_count++;
    if (g < e) begin
      err_count++;
      $display("wrong value %s expected at least %0d seen %0d", s, e, g);
    end
  endtask
  task automatic chk_lim(string s, int t);
    cmp_count++;
    if (t >= 2000) begin
      err_count++;
      $display("wrong value %s expected done seen timeout", s);
    end
  endtask
  task automatic access(edc_row_t r);
    int t;
    t = 0;
    @(negedge i_clk_sys);
    i_req_valid = 1'b1;
    i_req = '{r.wr, r.be, r.a, r.d};
    do @(negedge i_clk_sys); while (o_req_ready !== 1'b1 && ++t < 2000);
    i_req_valid = 1'b0;
    while (!r.wr && o_rvalid !== 1'b1 && ++t < 2000) @(negedge i_clk_sys);
    if (!r.wr) chk_d("read data", r.x, o_rdata);
    chk_lim("access wait", t);
  endtask
  task automatic restart;
    n = 0;
    r0 = refs;
    chk_d("reset outputs", 16'h001E, {11'h000, o_pins.ras_n, o_pins.low_byte_column_strobe_n,
          o_pins.high_byte_column_strobe_n, o_busy, o_pins.dq_oe});
    @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    while (o_pins.ras_n !== 1'b0 && ++n < 2000) @(negedge i_clk_sys);
    chk_n("power-up wait", 20, n);
    while (o_busy !== 1'b0 && ++n < 2000) @(negedge i_clk_sys);
    chk_lim("wake wait", n);
    chk_n("wake refreshes", r0 + 8, refs);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (20) @(negedge i_clk_sys);
    restart;
    $display("power-up test done");
    foreach (rows[i]) begin
      access(rows[i]);
      $display("row %0d done", i);
    end
    r0 = refs;
    repeat (1000) @(negedge i_clk_sys);
    chk_n("refresh count", r0 + 4, refs);
    $display("refresh test done");
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    restart;
    access(rows[7]);
    $display("mid-run reset test done");
    wrap_up;
  end
endmodule
